// ===== design/tcc_top.sv
// Top of the triple comparator control block: registers, muxes, ladder and pins
`timescale 1ns/1ps
`include "tcc_defs.svh"
// Operation
// [R1] Comparator runs only while its on bit set
// [R2] Pin drive bit puts result on pin
// [R3] Invert bit inverts result for all users
// [R4] Result bit reads comparison after polarity
// [R5] Event flag set; blocks further triggers
// [R6] Select 11: any result change triggers
// [R7] Select 10: falling edge, rising if inverted
// [R8] Select 01: rising edge, falling if inverted
// [R9] Select 00: no triggers at all
// [R10] Noninverting input: reference or pin A
// [R11] Inverting input: pins B, C, D, bandgap
// [R12] Halt bit stops all comparators in idle
// [R13] Status mirrors three event flags
// [R14] Status mirrors three result bits
// [R15] Reference select: external pin or ladder
// [R16] Bandgap source: full, half, sixth, pin
// [R17] Ladder power bit powers ladder
// [R18] Ladder pin bit drives reference pin
// [R19] Range bit picks step size and start
// [R20] Supply bit picks external or analog rails
// [R21] Level field passed as ladder tap
// [R22] Software waits for reference settling
// [R23] Pin result is not clock synchronised
// [R24] Result synchronised, edge compared, write clears
module tcc_top
    import tcc_pkg::*;
(
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    // Register port
    input  wire logic [2:0]  addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [15:0] rdata_out,
    // Device idle mode
    input  wire logic        idle_mode_in,
    // Analog comparator cores
    input  wire logic [2:0]  cmp_raw_in,
    output logic      [2:0]  cmp_power_out,
    output logic      [2:0]  noninv_pin_a_out,
    output logic      [2:0]  noninv_ladder_out,
    output logic      [2:0]  noninv_extref_out,
    output logic      [5:0]  inv_input_sel_out,
    output logic      [2:0]  inv_bandgap_out,
    // Comparator result pins
    output logic      [2:0]  cmp_result_pin_out,
    output logic      [2:0]  cmp_result_pin_oe_out,
    // Trigger and event pulses
    output logic      [2:0]  cmp_event_out,
    // Reference ladder
    output logic             ladder_power_on_out,
    output logic             ladder_pin_drive_out,
    output logic             ladder_range_sel_out,
    output logic             ladder_supply_sel_out,
    output logic      [3:0]  ladder_level_code_out,
    output logic      [1:0]  bandgap_source_sel_out
);
    tcc_top_s    s;
    tcc_top_s    next_s;
    logic [2:0]  active;
    logic [2:0]  flag_w;
    logic [2:0]  result_w;
    logic [2:0]  trig_w;
    logic [2:0]  ctl_wr;
    logic [15:0] ctl_word [3];
    logic [15:0] stat_word;
    logic [15:0] lad_word;

    tcc_if ch_if [3] ();

    // ------------------------------------------------------------
    // Per comparator channels
    // ------------------------------------------------------------
    for (genvar g = 0; g < 3; g++) begin : gen_chan
        // [R1] enable gates operation
        // [R12] idle halt stops all
        assign active[g] = s.ctl[g].on & ~(s.halt & idle_mode_in);
        assign ctl_wr[g] = wr_in & (addr_in == (`TCC_ADDR_CTL1 + 3'(g)));

        assign ch_if[g].on         = s.ctl[g].on;
        assign ch_if[g].invert     = s.ctl[g].invert;
        assign ch_if[g].edge_sel   = s.ctl[g].edge_sel;
        assign ch_if[g].active     = active[g];
        // [R24] software writes the flag
        assign ch_if[g].flag_wr    = ctl_wr[g];
        assign ch_if[g].flag_wdata = wdata_in[`TCC_CTL_FLAG];
        assign flag_w[g]           = ch_if[g].flag;
        assign result_w[g]         = ch_if[g].result;
        assign trig_w[g]           = ch_if[g].trig;

        tcc_chan u_chan (
            .clock_in (clock_in),
            .rst_in   (rst_in),
            .raw_in   (cmp_raw_in[g]),
            .bus      (ch_if[g])
        );

        // [R4] result and flag readback
        always_comb begin
            ctl_word[g]                                      = `TCC_RST_WORD;
            ctl_word[g][`TCC_CTL_ON]                         = s.ctl[g].on;
            ctl_word[g][`TCC_CTL_DRIVE]                      = s.ctl[g].drive;
            ctl_word[g][`TCC_CTL_INV]                        = s.ctl[g].invert;
            ctl_word[g][`TCC_CTL_FLAG]                       = flag_w[g];
            ctl_word[g][`TCC_CTL_RES]                        = result_w[g];
            ctl_word[g][`TCC_CTL_EDGE_HI:`TCC_CTL_EDGE_LO]   = s.ctl[g].edge_sel;
            ctl_word[g][`TCC_CTL_NONINV]                     = s.ctl[g].noninv;
            ctl_word[g][`TCC_CTL_INSEL_HI:`TCC_CTL_INSEL_LO] = s.ctl[g].inv_sel;
        end

        // [R1] analog core power
        assign cmp_power_out[g] = active[g];
        // [R10] noninverting input source
        // [R15] reference or external pin
        assign noninv_pin_a_out[g]  = ~s.ctl[g].noninv;
        assign noninv_ladder_out[g] = s.ctl[g].noninv & ~s.lad.extref_sel;
        assign noninv_extref_out[g] = s.ctl[g].noninv & s.lad.extref_sel;
        // [R11] inverting input select
        assign inv_input_sel_out[2*g+1:2*g] = s.ctl[g].inv_sel;
        // [R16] bandgap path on code 11
        assign inv_bandgap_out[g] = &s.ctl[g].inv_sel;
        // [R2] pin drive enable
        // [R23] unsynchronised pin path
        assign cmp_result_pin_oe_out[g] = s.ctl[g].on & s.ctl[g].drive;
        assign cmp_result_pin_out[g]    = s.ctl[g].on & s.ctl[g].drive
                                          & (cmp_raw_in[g] ^ s.ctl[g].invert);
        // [R5] trigger pulse out
        assign cmp_event_out[g] = trig_w[g];
    end

    // ------------------------------------------------------------
    // Status and ladder words
    // ------------------------------------------------------------
    always_comb begin
        stat_word                                   = `TCC_RST_WORD;
        stat_word[`TCC_STAT_HALT]                   = s.halt;
        // [R13] event flag mirrors
        stat_word[`TCC_STAT_EVT_HI:`TCC_STAT_EVT_LO] = flag_w;
        // [R14] result mirrors
        stat_word[`TCC_STAT_RES_HI:`TCC_STAT_RES_LO] = result_w;
        lad_word                                    = `TCC_RST_WORD;
        lad_word[`TCC_LAD_EXTREF]                   = s.lad.extref_sel;
        lad_word[`TCC_LAD_BG_HI:`TCC_LAD_BG_LO]     = s.lad.bg_sel;
        lad_word[`TCC_LAD_POWER]                    = s.lad.power;
        lad_word[`TCC_LAD_PIN]                      = s.lad.pin_drive;
        lad_word[`TCC_LAD_RANGE]                    = s.lad.range;
        lad_word[`TCC_LAD_SUPPLY]                   = s.lad.supply;
        lad_word[`TCC_LAD_LVL_HI:`TCC_LAD_LVL_LO]   = s.lad.level;
    end

    // ------------------------------------------------------------
    // Register writes and read data
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        for (int i = 0; i < 3; i++) begin
            if (ctl_wr[i]) begin
                // [R1] enable bit stored
                next_s.ctl[i].on       = wdata_in[`TCC_CTL_ON];
                next_s.ctl[i].drive    = wdata_in[`TCC_CTL_DRIVE];
                next_s.ctl[i].invert   = wdata_in[`TCC_CTL_INV];
                next_s.ctl[i].edge_sel =
                    tcc_edge_e'(wdata_in[`TCC_CTL_EDGE_HI:`TCC_CTL_EDGE_LO]);
                next_s.ctl[i].noninv   = wdata_in[`TCC_CTL_NONINV];
                next_s.ctl[i].inv_sel  = wdata_in[`TCC_CTL_INSEL_HI:`TCC_CTL_INSEL_LO];
            end
        end
        if (wr_in && addr_in == `TCC_ADDR_STAT) begin
            // [R12] halt bit stored
            next_s.halt = wdata_in[`TCC_STAT_HALT];
        end
        if (wr_in && addr_in == `TCC_ADDR_LAD) begin
            next_s.lad.extref_sel = wdata_in[`TCC_LAD_EXTREF];
            next_s.lad.bg_sel     = wdata_in[`TCC_LAD_BG_HI:`TCC_LAD_BG_LO];
            next_s.lad.power      = wdata_in[`TCC_LAD_POWER];
            next_s.lad.pin_drive  = wdata_in[`TCC_LAD_PIN];
            next_s.lad.range      = wdata_in[`TCC_LAD_RANGE];
            next_s.lad.supply     = wdata_in[`TCC_LAD_SUPPLY];
            next_s.lad.level      = wdata_in[`TCC_LAD_LVL_HI:`TCC_LAD_LVL_LO];
        end
        // Read data stands one cycle only, zero otherwise
        next_s.rdata = `TCC_RST_WORD;
        if (rd_in) begin
            unique case (addr_in)
                `TCC_ADDR_CTL1: next_s.rdata = ctl_word[0];
                `TCC_ADDR_CTL2: next_s.rdata = ctl_word[1];
                `TCC_ADDR_CTL3: next_s.rdata = ctl_word[2];
                `TCC_ADDR_STAT: next_s.rdata = stat_word;
                `TCC_ADDR_LAD:  next_s.rdata = lad_word;
                default:        next_s.rdata = `TCC_RST_WORD;
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rdata_out = s.rdata;

    // ------------------------------------------------------------
    // Reference ladder controls
    // ------------------------------------------------------------
    // [R17] ladder power
    assign ladder_power_on_out    = s.lad.power;
    // [R18] ladder pin output
    assign ladder_pin_drive_out   = s.lad.pin_drive;
    // [R19] range select
    assign ladder_range_sel_out   = s.lad.range;
    // [R20] supply select
    assign ladder_supply_sel_out  = s.lad.supply;
    // [R21] tap code unchanged
    assign ladder_level_code_out  = s.lad.level;
    // [R16] bandgap source select
    assign bandgap_source_sel_out = s.lad.bg_sel;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence seq_wr_ctl1;
        wr_in && addr_in == `TCC_ADDR_CTL1;
    endsequence

    sequence seq_rd_ctl1;
        rd_in && addr_in == `TCC_ADDR_CTL1;
    endsequence

    chk_ctl_readback: assert property (  // [R1]
        @(posedge clock_in) disable iff (rst_in)
        (seq_wr_ctl1 ##1 !wr_in ##1 seq_rd_ctl1)
        |=> (rdata_out[`TCC_CTL_ON] == $past(wdata_in[`TCC_CTL_ON], 3))
            && (rdata_out[`TCC_CTL_INSEL_HI:`TCC_CTL_INSEL_LO]
                == $past(wdata_in[`TCC_CTL_INSEL_HI:`TCC_CTL_INSEL_LO], 3)))
        else $error("control word did not read back as written");

    chk_halt_stops: assert property (  // [R12]
        @(posedge clock_in) disable iff (rst_in)
        (s.halt && idle_mode_in) |-> (cmp_power_out == 3'h0) && (cmp_event_out == 3'h0))
        else $error("comparator kept running in idle with halt set");

    chk_off_quiet: assert property (  // [R1]
        @(posedge clock_in) disable iff (rst_in)
        !s.ctl[0].on |-> !cmp_power_out[0] && !cmp_event_out[0] && !result_w[0])
        else $error("disabled comparator still active");

    chk_pin_drive: assert property (  // [R2]
        @(posedge clock_in) disable iff (rst_in)
        cmp_result_pin_oe_out[1]
        |-> cmp_result_pin_out[1] == (cmp_raw_in[1] ^ s.ctl[1].invert))
        else $error("driven pin does not carry the result");

    chk_status_mirror: assert property (  // [R13]
        @(posedge clock_in) disable iff (rst_in)
        (rd_in && addr_in == `TCC_ADDR_STAT)
        |=> (rdata_out[`TCC_STAT_EVT_HI:`TCC_STAT_EVT_LO] == $past(flag_w))
            && (rdata_out[`TCC_STAT_RES_HI:`TCC_STAT_RES_LO] == $past(result_w)))
        else $error("status does not mirror flags and results");

    chk_noninv_route: assert property (  // [R15]
        @(posedge clock_in) disable iff (rst_in)
        s.ctl[1].noninv |-> (noninv_extref_out[1] == s.lad.extref_sel)
                            && (noninv_ladder_out[1] != s.lad.extref_sel)
                            && !noninv_pin_a_out[1])
        else $error("noninverting source routed wrongly");

    chk_read_pulse: assert property (  // read data zero without a read
        @(posedge clock_in) disable iff (rst_in)
        !rd_in |=> rdata_out == 16'h0000)
        else $error("read data present without a read");
endmodule : tcc_top

// ===== design/tcc_defs.svh
// Register offsets, field positions and reset values of the comparator control block
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH
// ------------------------------------------------------------
// Register word addresses
// ------------------------------------------------------------
`define TCC_ADDR_CTL1    3'h0
`define TCC_ADDR_CTL2    3'h1
`define TCC_ADDR_CTL3    3'h2
`define TCC_ADDR_STAT    3'h3
`define TCC_ADDR_LAD     3'h4
// ------------------------------------------------------------
// Comparator control fields
// ------------------------------------------------------------
`define TCC_CTL_ON       15
`define TCC_CTL_DRIVE    14
`define TCC_CTL_INV      13
`define TCC_CTL_FLAG     9
`define TCC_CTL_RES      8
`define TCC_CTL_EDGE_HI  7
`define TCC_CTL_EDGE_LO  6
`define TCC_CTL_NONINV   4
`define TCC_CTL_INSEL_HI 1
`define TCC_CTL_INSEL_LO 0
// ------------------------------------------------------------
// Status fields
// ------------------------------------------------------------
`define TCC_STAT_HALT    15
`define TCC_STAT_EVT_HI  10
`define TCC_STAT_EVT_LO  8
`define TCC_STAT_RES_HI  2
`define TCC_STAT_RES_LO  0
// ------------------------------------------------------------
// Ladder control fields
// ------------------------------------------------------------
`define TCC_LAD_EXTREF   10
`define TCC_LAD_BG_HI    9
`define TCC_LAD_BG_LO    8
`define TCC_LAD_POWER    7
`define TCC_LAD_PIN      6
`define TCC_LAD_RANGE    5
`define TCC_LAD_SUPPLY   4
`define TCC_LAD_LVL_HI   3
`define TCC_LAD_LVL_LO   0
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define TCC_RST_WORD     16'h0000
`define TCC_RST_BIT      1'b0
`endif

// ===== design/tcc_pkg.sv
// Types shared by the comparator control modules
package tcc_pkg;
    typedef enum logic [1:0] {
        TCC_EDGE_NONE = 2'b00,
        TCC_EDGE_UP   = 2'b01,
        TCC_EDGE_DOWN = 2'b10,
        TCC_EDGE_ANY  = 2'b11
    } tcc_edge_e;

    typedef struct packed {
        logic      on;
        logic      drive;
        logic      invert;
        tcc_edge_e edge_sel;
        logic      noninv;
        logic [1:0] inv_sel;
    } tcc_ctl_s;

    typedef struct packed {
        logic       extref_sel;
        logic [1:0] bg_sel;
        logic       power;
        logic       pin_drive;
        logic       range;
        logic       supply;
        logic [3:0] level;
    } tcc_lad_s;

    typedef struct packed {
        tcc_ctl_s [2:0] ctl;
        logic           halt;
        tcc_lad_s       lad;
        logic [15:0]    rdata;
    } tcc_top_s;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic flag;
    } tcc_chan_s;
endpackage : tcc_pkg

// ===== design/tcc_if.sv
// Control and status carrier between the top and one comparator channel
`timescale 1ns/1ps
interface tcc_if;
    import tcc_pkg::*;
    logic      on;
    logic      invert;
    tcc_edge_e edge_sel;
    logic      active;
    logic      flag_wr;
    logic      flag_wdata;
    logic      result;
    logic      flag;
    logic      trig;
    modport top  (output on, invert, edge_sel, active, flag_wr, flag_wdata,
                  input  result, flag, trig);
    modport chan (input  on, invert, edge_sel, active, flag_wr, flag_wdata,
                  output result, flag, trig);
endinterface : tcc_if

// ===== design/tcc_chan.sv
// One comparator channel: result synchroniser, edge detection and event flag
`timescale 1ns/1ps
module tcc_chan
    import tcc_pkg::*;
(
    // Clock and reset
    input  wire logic clock_in,
    input  wire logic rst_in,
    // Raw comparator output, asynchronous
    input  wire logic raw_in,
    // Control and status
    tcc_if.chan       bus
);
    tcc_chan_s s;
    tcc_chan_s next_s;
    logic      cur;
    logic      hit;
    logic      trig;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        // [R24] two-flop sampling
        next_s.sync1 = raw_in;
        next_s.sync2 = s.sync1;
        // [R3] polarity applied once
        cur = bus.on ? (s.sync2 ^ bus.invert) : 1'b0;
        next_s.prev = cur;
        unique case (bus.edge_sel)
            // [R9] events disabled
            TCC_EDGE_NONE: hit = 1'b0;
            // [R8] rising edge select
            TCC_EDGE_UP:   hit = bus.invert ? (s.prev & ~cur) : (~s.prev & cur);
            // [R7] falling edge select
            TCC_EDGE_DOWN: hit = bus.invert ? (~s.prev & cur) : (s.prev & ~cur);
            // [R6] any change
            TCC_EDGE_ANY:  hit = s.prev ^ cur;
        endcase
        // [R5] flag blocks triggers
        trig = bus.active & hit & ~s.flag;
        // [R24] software write, set wins
        if (bus.flag_wr) begin
            next_s.flag = bus.flag_wdata;
        end
        if (trig) begin
            next_s.flag = 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign bus.result = cur;
    assign bus.flag   = s.flag;
    assign bus.trig   = trig;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence seq_armed;
        bus.active && !s.flag && !bus.invert;
    endsequence

    chk_flag_holds: assert property (  // [R5]
        @(posedge clock_in) disable iff (rst_in)
        (s.flag && !bus.flag_wr) |=> s.flag [*1] ##0 !$past(trig))
        else $error("event flag dropped or trigger while flag set");

    chk_up_event: assert property (  // [R8]
        @(posedge clock_in) disable iff (rst_in)
        (seq_armed ##0 (bus.edge_sel == TCC_EDGE_UP) ##0 (!s.prev && cur)) |=> s.flag)
        else $error("rising result did not set event flag");

    chk_down_event: assert property (  // [R7]
        @(posedge clock_in) disable iff (rst_in)
        (seq_armed ##0 (bus.edge_sel == TCC_EDGE_DOWN) ##0 (s.prev && !cur)) |=> s.flag)
        else $error("falling result did not set event flag");

    chk_any_event: assert property (  // [R6]
        @(posedge clock_in) disable iff (rst_in)
        (bus.active && !s.flag && bus.edge_sel == TCC_EDGE_ANY && (s.prev != cur))
        |=> s.flag)
        else $error("result change did not set event flag");

    chk_none_quiet: assert property (  // [R9]
        @(posedge clock_in) disable iff (rst_in)
        (bus.edge_sel == TCC_EDGE_NONE && !s.flag && !bus.flag_wr) |=> !s.flag)
        else $error("event flag set with events disabled");

    chk_sync_result: assert property (  // [R24]
        @(posedge clock_in) disable iff (rst_in)
        (bus.on && !$past(rst_in) && !$past(rst_in, 2))
        |-> (cur == ($past(raw_in, 2) ^ bus.invert)))
        else $error("result not the raw input two cycles back");
endmodule : tcc_chan

// ===== tb/tcc_analog_model.sv
// Behavioural model of the three analog comparator cores
`timescale 1ns/1ps
module tcc_analog_model (
    // Core run enables
    input  wire logic [2:0] power_in,
    // Commanded comparison outcome, input plus above input minus
    input  wire logic [2:0] cmd_in,
    // Raw core outputs, unsynchronised
    output logic      [2:0] raw_out
);
    // ------------------------------------------------------------
    // Core outputs
    // ------------------------------------------------------------
    // Cores unpowered read low
    assign raw_out = cmd_in & power_in;
endmodule : tcc_analog_model

// ===== tb/tb.sv
// Self-checking bench for the triple comparator control block
`timescale 1ns/1ps
module tb;
    import tcc_pkg::*;
    logic clock_in, rst_in, wr_in, rd_in, idle_mode_in;
    logic [2:0] addr_in, cmd, raw, pwr, pa, pl, pe, bgi, pin, oe, evt;
    logic [15:0] wdata_in, rdata_out;
    logic [5:0] isel;
    logic lp, lpin, lr, ls;
    logic [3:0] lvl;
    logic [1:0] bgs;
    int err_total = 0, samples_checked = 0, cyc = 0, cnt;
    logic [34:0] rows [5] = '{{3'h1, 16'h00d3, 16'h00d3}, {3'h2, 16'h1c2c, 16'h0000},
        {3'h3, 16'hffff, 16'h8000}, {3'h4, 16'hffff, 16'h07ff}, {3'h5, 16'hffff, 16'h0000}};
    tcc_top tcc_top_inst (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .idle_mode_in(idle_mode_in), .cmp_raw_in(raw), .cmp_power_out(pwr),
        .noninv_pin_a_out(pa), .noninv_ladder_out(pl), .noninv_extref_out(pe),
        .inv_input_sel_out(isel), .inv_bandgap_out(bgi), .cmp_result_pin_out(pin),
        .cmp_result_pin_oe_out(oe), .cmp_event_out(evt), .ladder_power_on_out(lp),
        .ladder_pin_drive_out(lpin), .ladder_range_sel_out(lr),
        .ladder_supply_sel_out(ls), .ladder_level_code_out(lvl),
        .bandgap_source_sel_out(bgs));
    tcc_analog_model tcc_analog_model_inst (.power_in(pwr), .cmd_in(cmd), .raw_out(raw));
    // ------------------------------------------------------------
    // Clock and timeout
    // ------------------------------------------------------------
    initial begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            conclude();
        end
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clock_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clock_in);
        wr_in    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [15:0] exp);
        @(posedge clock_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clock_in);
        rd_in   <= 1'b0;
        #1 check(rdata_out, exp);
    endtask : rd
    // Counts event pulses of comparator 1 over n cycles
    task automatic count_ev(input int n);
        cnt = 0;
        repeat (n) begin
            @(posedge clock_in);
            #1 if (evt[0] === 1'b1) cnt = cnt + 1;
        end
    endtask : count_ev
    task automatic set_raw(input logic v);
        @(posedge clock_in);
        cmd[0] <= v;
    endtask : set_raw
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_in = 1'b1; wr_in = 1'b0; rd_in = 1'b0; addr_in = 3'h0;
        wdata_in = 16'h0000; idle_mode_in = 1'b0; cmd = 3'h0;
        repeat (16) @(posedge clock_in);
        rst_in <= 1'b0;
        for (int a = 0; a < 5; a++) rd(3'(a), 16'h0000);
        check({pwr, oe, pin, evt, lp, lpin, lr, ls}, 16'h0000);
        $display("Reset test done");
        for (int i = 0; i < 5; i++) begin
            wr(rows[i][34:32], rows[i][31:16]);
            rd(rows[i][34:32], rows[i][15:0]);
        end
        check({pa, pl, pe, isel[5:2], bgi[2:1], 1'b0}, 16'ha11a);
        $display("Register table done");
        wr(3'h3, 16'h0000);
        wr(3'h4, 16'h0695);
        #1 check({6'h00, lp, lpin, lr, ls, lvl, bgs}, 16'h0256);
        wr(3'h0, 16'h8012);
        #1 check({9'h000, pa[0], pl[0], pe[0], isel[1:0], bgi[0], pwr[0]}, 16'h0019);
        rd(3'h0, 16'h8012);
        wr(3'h0, 16'h00c3);
        #1 check({9'h000, pa[0], pl[0], pe[0], isel[1:0], bgi[0], pwr[0]}, 16'h004e);
        set_raw(1'b1);
        count_ev(8);
        check(16'(cnt), 16'h0000);
        set_raw(1'b0);
        $display("Mux and ladder test done");
        // Select 01 fires on raw rise and 10 on raw fall whatever the invert bit
        for (int s = 0; s < 8; s++) begin
            wr(3'h0, {2'b11, s[2], 5'h00, s[1:0], 6'h00});
            repeat (6) @(posedge clock_in);
            wr(3'h0, {2'b11, s[2], 5'h00, s[1:0], 6'h00});
            set_raw(1'b1);
            #1 check({15'h0000, pin[0]}, {15'h0000, ~s[2]});
            count_ev(8);
            check(16'(cnt), {15'h0000, s[0]});
            rd(3'h3, {7'h00, s[0], 7'h00, ~s[2]});
            wr(3'h0, {2'b11, s[2], 5'h00, s[1:0], 6'h00});
            set_raw(1'b0);
            count_ev(8);
            check(16'(cnt), {15'h0000, s[1]});
        end
        $display("Edge select test done");
        wr(3'h0, 16'hc0c0);
        // Second write clears the flag set by the polarity change
        wr(3'h0, 16'hc0c0);
        set_raw(1'b1);
        count_ev(8);
        check(16'(cnt), 16'h0001);
        rd(3'h0, 16'hc3c0);
        set_raw(1'b0);
        count_ev(8);
        check(16'(cnt), 16'h0000);
        $display("Flag blocking test done");
        wr(3'h0, 16'hc0c0);
        wr(3'h3, 16'h8000);
        idle_mode_in <= 1'b1;
        @(posedge clock_in);
        #1 check({13'h0000, pwr}, 16'h0000);
        set_raw(1'b1);
        count_ev(8);
        check(16'(cnt), 16'h0000);
        idle_mode_in <= 1'b0;
        @(posedge clock_in);
        #1 check({13'h0000, pwr}, 16'h0001);
        wr(3'h3, 16'h0000);
        idle_mode_in <= 1'b1;
        @(posedge clock_in);
        #1 check({13'h0000, pwr}, 16'h0001);
        $display("Idle halt test done");
        conclude();
    end
endmodule : tb
